/* File: ats_top.sv */
/*
 * Auto test step sequencer with AHB-Lite register slave and connector.
 * Assumes connector inputs are asynchronous, meas_value is on clk_sys.
 */
// The address map and the AHB-Lite register port were left to the implementer.
// Behaviour
// - ten programs, hundred steps, retained storage (framework flops are cleared by arst_n)
// - ten-bit enable mask, only enabled steps run
// - selecting enabled step clears it (toggle)
// - pause flag halts step until continued
// - on time enables load at mode, setpoint
// - off time disables load after on time
// - pass/fail delay before limit measurement
// - stop condition: run all or stop on fail
// - chain index 0-10, nonzero starts that program
// - framework saved to slots one to ten
// - step k of program n uses group 10(n-1)+k
// - group holds mode, setpoint, upper, lower limits
// - groups written independently of framework
// - external start launches selected program
// - external pause suspends test at current step
// - external next advances or releases pause
// - external previous moves back one enabled step
// - connector output shows load switched on
// - separate fail and pass connector outputs
// - warning tone output on connector
// - analog mode: previous selects CC, next CV
// - keys pause and advance like external inputs
`timescale 1ns/1ps
`default_nettype none

module ats_top #(
  parameter int TICK = ats_pkg::TICK_CYCLES
) (
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output var  logic                hreadyout,
  output var  logic                hresp,
  output var  logic [31:0]         hrdata,
  input  wire logic                conn_start,
  input  wire logic                conn_pause,
  input  wire logic                conn_next,
  input  wire logic                conn_prev,
  input  wire logic [15:0]         meas_value,
  output var  logic                conn_input_on,
  output var  logic                conn_fail,
  output var  logic                conn_pass,
  output var  logic                conn_tone,
  output var  ats_pkg::ats_mode_t  load_mode,
  output var  logic [15:0]         load_setpoint
);
  import ats_pkg::*;

  ats_mem_if mif ();

  // ---------------- register bus ----------------
  logic        pend_q;
  logic        bwr_q;
  logic [7:0]  baddr_q;
  logic        accept;
  logic        wr_ev;
  logic        rd_ev;
  logic [31:0] rd_mux;

  // address phase taken only for an active transfer
  assign accept = hsel & htrans[1] & hready;
  assign wr_ev  = pend_q & bwr_q;
  assign rd_ev  = pend_q & ~bwr_q;

  // every transfer gets one wait state in its data phase
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pend_q    <= 1'b0;
      bwr_q     <= 1'b0;
      baddr_q   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      pend_q    <= accept;
      hreadyout <= ~accept;
      hresp     <= 1'b0;
      if (accept) begin
        bwr_q   <= hwrite;
        baddr_q <= haddr[7:0];
      end
      if (rd_ev) begin
        hrdata <= rd_mux;
      end
    end
  end

  // register write strobes
  logic wr_ctrl;
  logic wr_fw_sel;
  logic wr_fw_data;
  logic wr_toggle;
  logic wr_grp_sel;
  logic wr_grp_w;
  logic [5:0] widx;
  assign wr_ctrl    = wr_ev & (baddr_q == OFS_CTRL);
  assign wr_fw_sel  = wr_ev & (baddr_q == OFS_FW_SEL);
  assign wr_fw_data = wr_ev & (baddr_q == OFS_FW_DATA);
  assign wr_toggle  = wr_ev & (baddr_q == OFS_TOGGLE);
  assign wr_grp_sel = wr_ev & (baddr_q == OFS_GRP_SEL);
  assign wr_grp_w   = wr_ev & (baddr_q >= OFS_GRP_W0)
                            & (baddr_q <= OFS_GRP_W3);
  assign widx       = baddr_q[7:2] - OFS_GRP_W0[7:2];

  // control and selection registers
  logic [3:0] sel_prog_q;
  logic       analog_q;
  logic [3:0] fw_sel_q;
  logic [6:0] grp_sel_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sel_prog_q <= PROG_RST;
      analog_q   <= 1'b0;
      fw_sel_q   <= PROG_RST;
      grp_sel_q  <= GRP_RST;
    end else begin
      if (wr_ctrl) begin
        sel_prog_q <= hwdata[CTRL_PROG_LSB +: 4];
        analog_q   <= hwdata[CTRL_ANALOG];
      end
      if (wr_fw_sel) fw_sel_q <= hwdata[3:0];
      if (wr_grp_sel) grp_sel_q <= hwdata[6:0];
    end
  end

  // program framework slots 1..10 held in flops
  logic [9:0] fw_en_q    [NUM_PROG];
  logic [9:0] fw_pause_q [NUM_PROG];
  logic       fw_stop_q  [NUM_PROG];
  logic [3:0] fw_chain_q [NUM_PROG];
  logic       fw_ok;
  logic [3:0] fw_i;
  assign fw_ok = (fw_sel_q != 4'h0) && (fw_sel_q <= 4'(NUM_PROG));
  assign fw_i  = fw_ok ? fw_sel_q - 4'h1 : 4'h0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_PROG; i++) begin
        fw_en_q[i]    <= 10'h000;
        fw_pause_q[i] <= 10'h000;
        fw_stop_q[i]  <= 1'b0;
        fw_chain_q[i] <= 4'h0;
      end
    end else if (fw_ok && wr_fw_data) begin
      fw_en_q[fw_i]    <= hwdata[FW_EN_LSB +: 10];
      fw_pause_q[fw_i] <= hwdata[FW_PAUSE_LSB +: 10];
      fw_stop_q[fw_i]  <= hwdata[FW_STOP];
      fw_chain_q[fw_i] <= hwdata[FW_CHAIN_LSB +: 4];
    end else if (fw_ok && wr_toggle) begin
      fw_en_q[fw_i] <= fw_en_q[fw_i] ^ hwdata[9:0];
    end
  end

  // step groups go straight to memory, one word at a time
  logic grp_ok;
  assign grp_ok    = (grp_sel_q != 7'h00) && (grp_sel_q <= 7'(NUM_GRP));
  assign mif.we    = wr_grp_w & grp_ok;
  assign mif.waddr = {7'(grp_sel_q - 7'h01), widx[1:0]};
  assign mif.wdata = hwdata;

  ats_mem #(
    .DEPTH (MEM_DEPTH)
  ) u_mem (
    .clk_sys (clk_sys),
    .mp      (mif.mem)
  );

  // ---------------- connector inputs ----------------
  logic [3:0] pin_lv;
  logic [3:0] pin_prev_q;
  logic [3:0] pin_edge;
  ats_sync #(
    .W (4)
  ) u_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .d       ({conn_prev, conn_next, conn_pause, conn_start}),
    .q       (pin_lv)
  );

  // one command per rising level after filtering
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) pin_prev_q <= 4'h0;
    else pin_prev_q <= pin_lv;
  end
  assign pin_edge = pin_lv & ~pin_prev_q;

  // command merge: pins, keys and software start
  logic cmd_start;
  logic cmd_pause;
  logic cmd_next;
  logic cmd_prev;
  logic ana_cc;
  logic ana_cv;
  assign cmd_start = pin_edge[0] | (wr_ctrl & hwdata[CTRL_START]);
  assign cmd_pause = pin_edge[1] | (wr_ctrl & hwdata[CTRL_KPAUSE]);
  assign cmd_next  = (pin_edge[2] & ~analog_q)
                   | (wr_ctrl & hwdata[CTRL_KNEXT]);
  assign cmd_prev  = pin_edge[3] & ~analog_q;
  assign ana_cc    = pin_edge[3] & analog_q;
  assign ana_cv    = pin_edge[2] & analog_q;

  // ---------------- sequencer ----------------
  function automatic logic [4:0] find_en(input logic [9:0] m,
                                         input logic [3:0] cur,
                                         input logic fwd,
                                         input logic incl);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NUM_STEP - 1; i >= 0; i--) begin
      if (fwd && m[i] && (i > int'(cur) || (incl && i == int'(cur)))) begin
        r = {1'b1, 4'(i)};
      end
    end
    for (int i = 0; i < NUM_STEP; i++) begin
      if (!fwd && m[i] && i < int'(cur)) r = {1'b1, 4'(i)};
    end
    return r;
  endfunction

  ats_state_t  state_q, state_d, ret_q, ret_d;
  logic [3:0]  prog_q, prog_d, step_q, step_d;
  logic [2:0]  fw_q, fw_d;
  ats_mode_t   mode_q, mode_d;
  logic [15:0] setp_q, setp_d, upper_q, upper_d, lower_q, lower_d;
  logic [15:0] on_t_q, on_t_d, off_t_q, off_t_d, pf_t_q, pf_t_d;
  logic [15:0] tick_q, tick_d, ms_q, ms_d, tone_ms_q, tone_ms_d;
  logic        measured_q, measured_d, sfail_q, sfail_d;
  logic        rfail_q, rfail_d, pass_q, pass_d, fail_q, fail_d;
  logic        tone_q, tone_d, ana_cv_q, ana_cv_d;

  // live views of the running program's framework
  logic [3:0]  pi;
  logic [9:0]  cur_en;
  logic [4:0]  nxt_hit;
  logic [4:0]  prv_hit;
  logic [4:0]  sel_first;
  logic [4:0]  chn_first;
  logic [3:0]  chain;
  logic        sel_ok;
  logic        chain_ok;
  logic        tick_end;
  logic        viol;
  logic [6:0]  grp_m1;
  assign pi        = prog_q - 4'h1;
  assign cur_en    = fw_en_q[pi];
  assign chain     = fw_chain_q[pi];
  assign chain_ok  = (chain != 4'h0) && (chain <= 4'(NUM_PROG));
  assign sel_ok    = (sel_prog_q != 4'h0) && (sel_prog_q <= 4'(NUM_PROG));
  assign nxt_hit   = find_en(cur_en, step_q, 1'b1, 1'b0);
  assign prv_hit   = find_en(cur_en, step_q, 1'b0, 1'b0);
  assign sel_first = find_en(fw_en_q[sel_prog_q - 4'h1], 4'h0, 1'b1, 1'b1);
  assign chn_first = find_en(fw_en_q[chain - 4'h1], 4'h0, 1'b1, 1'b1);
  assign tick_end  = (tick_q == 16'(TICK - 1));
  assign viol      = (meas_value < lower_q) || (meas_value > upper_q);
  assign grp_m1    = 7'((7'(prog_q) - 7'h01) * 7'd10 + 7'(step_q));
  assign mif.raddr = {grp_m1, fw_q[1:0]};

  // next-state and datapath
  always_comb begin
    state_d = state_q; ret_d = ret_q; prog_d = prog_q; step_d = step_q;
    fw_d = fw_q; mode_d = mode_q; setp_d = setp_q;
    upper_d = upper_q; lower_d = lower_q;
    on_t_d = on_t_q; off_t_d = off_t_q; pf_t_d = pf_t_q;
    tick_d = tick_end ? 16'h0000 : tick_q + 16'h0001;
    ms_d = tick_end ? ms_q + 16'h0001 : ms_q;
    measured_d = measured_q; sfail_d = sfail_q; rfail_d = rfail_q;
    pass_d = pass_q; fail_d = fail_q; ana_cv_d = ana_cv_q;
    tone_ms_d = (tick_end && tone_ms_q != 16'h0000) ? tone_ms_q - 16'h0001
                                                    : tone_ms_q;
    tone_d = (tone_ms_q != 16'h0000);
    if (ana_cc) ana_cv_d = 1'b0;
    if (ana_cv) ana_cv_d = 1'b1;
    case (state_q)
      st_idle: begin
        if (cmd_start && sel_ok) begin
          prog_d = sel_prog_q; rfail_d = 1'b0;
          pass_d = 1'b0; fail_d = 1'b0;
          step_d = sel_first[3:0]; fw_d = 3'h0;
          state_d = sel_first[4] ? st_fetch : st_end;
        end
      end
      st_fetch: begin
        fw_d = fw_q + 3'h1;
        case (fw_q)
          3'h1: begin
            setp_d = mif.rdata[15:0];
            mode_d = ats_mode_t'(mif.rdata[W0_MODE_LSB +: 2]);
          end
          3'h2: begin
            lower_d = mif.rdata[15:0];
            upper_d = mif.rdata[W1_UPPER_LSB +: 16];
          end
          3'h3: begin
            on_t_d  = mif.rdata[15:0];
            off_t_d = mif.rdata[W2_OFF_LSB +: 16];
          end
          3'h4: begin
            pf_t_d = mif.rdata[15:0];
            tick_d = 16'h0000; ms_d = 16'h0000;
            measured_d = 1'b0; sfail_d = 1'b0;
            if (fw_pause_q[pi][step_q]) begin
              state_d = st_paused; ret_d = st_on;
            end else begin
              state_d = st_on;
            end
          end
          default: ;
        endcase
      end
      st_on: begin
        if (!measured_q && (ms_q >= pf_t_q || ms_q >= on_t_q)) begin
          measured_d = 1'b1; sfail_d = viol;
          rfail_d = rfail_q | viol;
        end
        if (measured_q && ms_q >= on_t_q) begin
          state_d = st_off; tick_d = 16'h0000; ms_d = 16'h0000;
        end
      end
      st_off: begin
        if (ms_q >= off_t_q) state_d = st_adv;
      end
      st_paused: begin
        tick_d = tick_q; ms_d = ms_q;                 // timers frozen
        if (cmd_next) state_d = ret_q;
      end
      st_adv: begin
        fw_d = 3'h0;
        if (sfail_q && fw_stop_q[pi]) state_d = st_end;
        else if (nxt_hit[4]) begin
          step_d = nxt_hit[3:0]; state_d = st_fetch;
        end else state_d = st_end;
      end
      st_end: begin
        fw_d = 3'h0;
        if (chain_ok) begin
          prog_d = chain; step_d = chn_first[3:0];
          state_d = chn_first[4] ? st_fetch : st_end;
        end else begin
          pass_d = ~rfail_q; fail_d = rfail_q;
          tone_ms_d = 16'(TONE_MS); state_d = st_idle;
        end
      end
      default: state_d = st_idle;
    endcase
    // operator moves override the step flow while a run is live
    if (state_q != st_idle && state_q != st_end) begin
      if (cmd_prev) begin
        if (prv_hit[4]) step_d = prv_hit[3:0];
        else step_d = step_q;
        fw_d = 3'h0; state_d = st_fetch;
      end else if (cmd_next && state_q != st_paused) begin
        state_d = st_adv; sfail_d = 1'b0;
      end else if (cmd_pause && (state_q == st_on || state_q == st_off)) begin
        ret_d = state_q; state_d = st_paused;
      end
    end
  end

  // sequencer state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= st_idle; ret_q <= st_on;
      prog_q <= PROG_RST; step_q <= 4'h0; fw_q <= 3'h0;
      mode_q <= constant_current_mode; setp_q <= 16'h0000;
      upper_q <= 16'h0000; lower_q <= 16'h0000;
      on_t_q <= 16'h0000; off_t_q <= 16'h0000; pf_t_q <= 16'h0000;
      tick_q <= 16'h0000; ms_q <= 16'h0000; tone_ms_q <= 16'h0000;
      measured_q <= 1'b0; sfail_q <= 1'b0; rfail_q <= 1'b0;
      pass_q <= 1'b0; fail_q <= 1'b0; tone_q <= 1'b0; ana_cv_q <= 1'b0;
    end else begin
      state_q <= state_d; ret_q <= ret_d;
      prog_q <= prog_d; step_q <= step_d; fw_q <= fw_d;
      mode_q <= mode_d; setp_q <= setp_d;
      upper_q <= upper_d; lower_q <= lower_d;
      on_t_q <= on_t_d; off_t_q <= off_t_d; pf_t_q <= pf_t_d;
      tick_q <= tick_d; ms_q <= ms_d; tone_ms_q <= tone_ms_d;
      measured_q <= measured_d; sfail_q <= sfail_d; rfail_q <= rfail_d;
      pass_q <= pass_d; fail_q <= fail_d; tone_q <= tone_d;
      ana_cv_q <= ana_cv_d;
    end
  end

  // connector and load outputs, all registered
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      conn_input_on <= 1'b0;
      conn_fail     <= 1'b0;
      conn_pass     <= 1'b0;
      conn_tone     <= 1'b0;
      load_mode     <= constant_current_mode;
      load_setpoint <= 16'h0000;
    end else begin
      conn_input_on <= (state_d == st_on);
      conn_fail     <= fail_d;
      conn_pass     <= pass_d;
      conn_tone     <= tone_d;
      load_mode     <= analog_q ? (ana_cv_d ? constant_voltage_mode
                                            : constant_current_mode)
                                : mode_d;
      load_setpoint <= setp_d;
    end
  end

  // read data selection
  assign rd_mux =
      (baddr_q == OFS_CTRL)    ? {27'h0, analog_q, sel_prog_q} :
      (baddr_q == OFS_STATUS)  ? {17'h0, tone_q, (state_q != st_idle),
                                  fail_q, pass_q, state_q,
                                  4'(step_q + 4'h1), prog_q} :
      (baddr_q == OFS_FW_SEL)  ? {28'h0, fw_sel_q} :
      (baddr_q == OFS_FW_DATA) ? {7'h0, fw_chain_q[fw_i], fw_stop_q[fw_i],
                                  fw_pause_q[fw_i], fw_en_q[fw_i]} :
      (baddr_q == OFS_GRP_SEL) ? {25'h0, grp_sel_q} : 32'h0000_0000;
endmodule

`default_nettype wire

/* File: ats_pkg.sv */
/*
 * Constants, register map and types shared by the auto test sequencer.
 * Assumes a 10 MHz system clock and 32-bit AHB-Lite register access.
 */
`default_nettype none

package ats_pkg;

  // storage geometry
  localparam int NUM_PROG  = 10;
  localparam int NUM_STEP  = 10;
  localparam int NUM_GRP   = 100;
  localparam int GRP_WORDS = 4;
  localparam int MEM_AW    = 9;
  localparam int MEM_DW    = 32;
  localparam int MEM_DEPTH = NUM_GRP * GRP_WORDS;

  // timing: one time unit of every step time is one millisecond
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIME_UNIT_NS  = 1_000_000;
  localparam int TICK_CYCLES   = TIME_UNIT_NS / CLK_PERIOD_NS;
  localparam int TONE_MS       = 500;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_FW_SEL  = 8'h08;
  localparam logic [7:0] OFS_FW_DATA = 8'h0C;
  localparam logic [7:0] OFS_TOGGLE  = 8'h10;
  localparam logic [7:0] OFS_GRP_SEL = 8'h14;
  localparam logic [7:0] OFS_GRP_W0  = 8'h18;
  localparam logic [7:0] OFS_GRP_W3  = 8'h24;

  // control register fields
  localparam int CTRL_PROG_LSB = 0;
  localparam int CTRL_ANALOG   = 4;
  localparam int CTRL_KPAUSE   = 5;
  localparam int CTRL_KNEXT    = 6;
  localparam int CTRL_START    = 7;

  // program framework word fields
  localparam int FW_EN_LSB    = 0;
  localparam int FW_PAUSE_LSB = 10;
  localparam int FW_STOP      = 20;
  localparam int FW_CHAIN_LSB = 21;

  // step group word fields
  localparam int W0_MODE_LSB  = 16;
  localparam int W1_UPPER_LSB = 16;
  localparam int W2_OFF_LSB   = 16;

  // reset values
  localparam logic [3:0] PROG_RST = 4'h1;
  localparam logic [6:0] GRP_RST  = 7'h01;

  typedef enum logic [1:0] {
    constant_current_mode    = 2'b00,
    constant_voltage_mode    = 2'b01,
    constant_resistance_mode = 2'b10,
    constant_power_mode      = 2'b11
  } ats_mode_t;

  typedef enum logic [2:0] {
    st_idle   = 3'b000,
    st_fetch  = 3'b001,
    st_on     = 3'b010,
    st_off    = 3'b011,
    st_paused = 3'b100,
    st_adv    = 3'b101,
    st_end    = 3'b110
  } ats_state_t;

endpackage

`default_nettype wire

/* File: ats_mem_if.sv */
/*
 * Port bundle between the sequencer and its step parameter memory.
 * Assumes one writer (register bus) and one reader (sequencer).
 */
`timescale 1ns/1ps
`default_nettype none

interface ats_mem_if;
  import ats_pkg::*;
  logic              we;
  logic [MEM_AW-1:0] waddr;
  logic [MEM_DW-1:0] wdata;
  logic [MEM_AW-1:0] raddr;
  logic [MEM_DW-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr,
                output rdata);
endinterface

`default_nettype wire

/* File: ats_sync.sv */
/*
 * Three-stage input synchroniser; the output moves only when the
 * second and third stages agree. Assumes asynchronous pin inputs.
 */
`timescale 1ns/1ps
`default_nettype none

module ats_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;

  // bits where the late stages match
  assign agree = ~(s2_q ^ s3_q);

  // shift chain and filtered output
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q    <= (agree & s3_q) | (~agree & q);
    end
  end
endmodule

`default_nettype wire

/* File: ats_mem.sv */
/*
 * Step parameter store, one write and one registered read port.
 * Assumes the array is backed by retained storage in the real chip.
 */
`timescale 1ns/1ps
`default_nettype none

module ats_mem #(
  parameter int DEPTH = ats_pkg::MEM_DEPTH
) (
  input wire logic clk_sys,
  ats_mem_if.mem   mp
);
  import ats_pkg::*;

  logic [MEM_DW-1:0] mem_q [DEPTH];

  // write and registered read
  always_ff @(posedge clk_sys) begin
    if (mp.we && (int'(mp.waddr) < DEPTH)) begin
      mem_q[mp.waddr] <= mp.wdata;
    end
    mp.rdata <= mem_q[mp.raddr];
  end
endmodule

`default_nettype wire

/* File: ats_top_monitor.sv */
/* checker of the sequencer's bus handshake and connector outputs.
   bound into ats_top below; sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none

module ats_top_monitor (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        conn_input_on,
  input wire logic        conn_pass,
  input wire logic        conn_fail,
  input wire logic        conn_tone,
  input wire logic [15:0] load_setpoint
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic take;
  // an address phase the slave accepts
  assign take = hsel && htrans[1] && hready;
  // exactly one wait state, then ready again
  sequence one_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence tone_on_s;
    conn_tone[*8];
  endsequence
  bus_wait_a: assert property (take |=> one_wait_s)
    else $error("bus wait state wrong");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(take))
    else $error("wait state without a transfer");
  resp_okay_a: assert property (!hresp)
    else $error("error response seen");
  verdict_excl_a: assert property (!(conn_pass && conn_fail))
    else $error("pass and fail together");
  run_clear_a: assert property (conn_input_on |-> !conn_pass && !conn_fail)
    else $error("verdict shown while loading");
  tone_cause_a: assert property ($rose(conn_tone) |-> ##[0:2] (conn_pass || conn_fail))
    else $error("tone without a verdict");
  tone_hold_a: assert property ($rose(conn_tone) |-> tone_on_s)
    else $error("tone too short");
  set_hold_a: assert property (conn_input_on && $past(conn_input_on) |-> $stable(load_setpoint))
    else $error("setpoint moved while loading");
endmodule

bind ats_top ats_top_monitor i_mon (
  .clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .conn_input_on(conn_input_on), .conn_pass(conn_pass),
  .conn_fail(conn_fail), .conn_tone(conn_tone),
  .load_setpoint(load_setpoint));

`default_nettype wire

/* File: ats_fixture.sv */
/* external fixture model that drives the connector pins.
   its tasks are called by the bench; runs on clk_sys. */
`timescale 1ns/1ps
`default_nettype none

module ats_fixture (
  input  wire logic        clk_sys,
  output var  logic        conn_start,
  output var  logic        conn_pause,
  output var  logic        conn_next,
  output var  logic        conn_prev,
  output var  logic [15:0] meas_value
);
  initial begin
    {conn_start, conn_pause, conn_next, conn_prev} = 4'h0;
    meas_value = 16'h0000;
  end
  // one whole press: six cycles high, then six low for the filter
  task automatic press(input int pin);
    @(posedge clk_sys);
    case (pin)
      0: conn_start <= 1'b1;
      1: conn_pause <= 1'b1;
      2: conn_next <= 1'b1;
      default: conn_prev <= 1'b1;
    endcase
    repeat (6) @(posedge clk_sys);
    {conn_start, conn_pause, conn_next, conn_prev} <= 4'h0;
    repeat (6) @(posedge clk_sys);
  endtask
  // quantity handed to the limit check
  task automatic set_meas(input logic [15:0] v);
    meas_value <= v;
  endtask
endmodule

`default_nettype wire

/* File: tb_auto_test_sequencer.sv */
/* bench for the auto test sequencer: bus tasks, runs and verdict.
   ats_top runs with a short tick; the fixture drives the pins. */
`timescale 1ns/1ps
`default_nettype none

module tb_auto_test_sequencer;
  import ats_pkg::*;
  localparam int TK = 4;
  logic        clk_sys, arst_n, hsel, hwrite, hreadyout, hresp;
  logic        conn_start, conn_pause, conn_next, conn_prev;
  logic        conn_input_on, conn_fail, conn_pass, conn_tone;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] meas_value, load_setpoint;
  logic [31:0] haddr, hwdata, hrdata, rd;
  ats_mode_t   load_mode;
  int          miscompares, checks_done, cyc;

  ats_top #(.TICK(TK)) i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .conn_start(conn_start), .conn_pause(conn_pause),
    .conn_next(conn_next), .conn_prev(conn_prev),
    .meas_value(meas_value), .conn_input_on(conn_input_on),
    .conn_fail(conn_fail), .conn_pass(conn_pass), .conn_tone(conn_tone),
    .load_mode(load_mode), .load_setpoint(load_setpoint));
  ats_fixture i_fix (.clk_sys(clk_sys), .conn_start(conn_start),
    .conn_pause(conn_pause), .conn_next(conn_next),
    .conn_prev(conn_prev), .meas_value(meas_value));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test;
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  // single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic run_end;
    while (conn_pass !== 1'b1 && conn_fail !== 1'b1) @(posedge clk_sys);
  endtask

  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    arst_n = 1'b0;
    miscompares = 0;
    checks_done = 0;
    cyc = 0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    // reset values, a write-only word and an unmapped word
    rdc("ctrl", OFS_CTRL, 32'h1);
    rdc("fw_sel", OFS_FW_SEL, 32'h1);
    rdc("grp_sel", OFS_GRP_SEL, 32'h1);
    rdc("grp_w0", OFS_GRP_W0, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h40, 32'h0);
    $display("test regs done");
    // program 2: steps 1 and 2 enabled, step 2 toggled off again
    wr(OFS_FW_SEL, 32'h2);
    wr(OFS_FW_DATA, 32'h3);
    wr(OFS_TOGGLE, 32'h2);
    for (int g = 11; g <= 12; g++) begin
      wr(OFS_GRP_SEL, 32'(g));
      wr(OFS_GRP_W0, 32'h0001_0123);
      wr(OFS_GRP_W0 + 8'h04, g == 11 ? 32'h0020_0010 : 32'h0200_0100);
      wr(OFS_GRP_W0 + 8'h08, 32'h0001_0002);
      wr(OFS_GRP_W3, 32'h1);
    end
    wr(OFS_CTRL, 32'h2);
    i_fix.set_meas(16'h0018);
    i_fix.press(0);
    while (conn_input_on !== 1'b1) @(posedge clk_sys);
    chk("setpoint", 32'h0123, {16'h0, load_setpoint});
    chk("mode", 32'h1, {30'h0, load_mode});
    run_end;
    chk("pass", 32'h1, {31'h0, conn_pass});
    chk("fail", 32'h0, {31'h0, conn_fail});
    $display("test run_pass done");
    // paused step released by next; reading out of limits
    wr(OFS_FW_DATA, 32'h0000_0401);
    i_fix.set_meas(16'h0030);
    i_fix.press(0);
    repeat (40) @(posedge clk_sys);
    chk("held", 32'h0, {31'h0, conn_input_on});
    i_fix.press(2);
    run_end;
    chk("fail", 32'h1, {31'h0, conn_fail});
    chk("pass", 32'h0, {31'h0, conn_pass});
    $display("test run_fail done");
    // key start, pin pause holds the step, key next resumes it
    wr(OFS_FW_DATA, 32'h1);
    wr(OFS_CTRL, 32'h82);
    while (conn_input_on !== 1'b1) @(posedge clk_sys);
    i_fix.press(1);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("paused", 32'h4, {29'h0, rd[10:8]});
    wr(OFS_CTRL, 32'h42);
    run_end;
    chk("key_fail", 32'h1, {31'h0, conn_fail});
    $display("test keys done");
    // analog mode: next picks voltage, previous picks current
    wr(OFS_CTRL, 32'h12);
    i_fix.press(2);
    chk("mode_cv", 32'h1, {30'h0, load_mode});
    i_fix.press(3);
    chk("mode_cc", 32'h0, {30'h0, load_mode});
    $display("test analog done");
    finish_test;
  end
endmodule

`default_nettype wire
